//--- logic/lpc_pkg.sv
// constants and types shared by the look-up table pair logic block
package lpc_pkg;
  localparam int NUM_TABLES = 2;
  typedef logic [3:0] lpc_addr_t;
  typedef logic [7:0] lpc_data_t;
  typedef logic [1:0] lpc_filt_t;
  typedef logic [3:0] lpc_insel_t;
  // register offsets
  localparam lpc_addr_t ADDR_BLOCK_CTRL = 4'h0;
  localparam lpc_addr_t ADDR_SEQ_CTRL = 4'h1;
  localparam lpc_addr_t ADDR_TBL_BASE = 4'h5;
  localparam lpc_addr_t TBL_STRIDE = 4'h4;
  localparam lpc_addr_t OFS_CTRL_A = 4'h0;
  localparam lpc_addr_t OFS_CTRL_B = 4'h1;
  localparam lpc_addr_t OFS_CTRL_C = 4'h2;
  localparam lpc_addr_t OFS_TRUTH = 4'h3;
  localparam lpc_data_t REG_RESET = 8'h00;
  // field positions
  localparam int BC_EN_BIT = 0;
  localparam int CA_EN_BIT = 0;
  localparam int CA_OUTEN_BIT = 3;
  localparam int CA_FILT_LO = 4;
  localparam int CA_TABLE_CLOCK_SOURCE_BIT = 6;
  localparam int CA_EDGE_BIT = 7;
  localparam int CB_IN0_LO = 0;
  localparam int CB_IN1_LO = 4;
  localparam int CC_IN2_LO = 0;
  localparam int SEL_W = 4;
  // sequencer function select encodings
  localparam logic [3:0] SEQ_OFF = 4'h0;
  localparam logic [3:0] SEQ_DFF = 4'h1;
  localparam logic [3:0] SEQ_JK = 4'h2;
  localparam logic [3:0] SEQ_DLATCH = 4'h3;
  localparam logic [3:0] SEQ_RS = 4'h4;
  // output filter select encodings
  localparam lpc_filt_t FILT_OFF = 2'h0;
  localparam lpc_filt_t FILT_SYNC = 2'h1;
  localparam lpc_filt_t FILT_FILTER = 2'h2;
  // table input select encodings
  localparam lpc_insel_t IN_MASK = 4'h0;
  localparam lpc_insel_t IN_FEEDBACK = 4'h1;
  localparam lpc_insel_t IN_LINK = 4'h2;
  localparam lpc_insel_t IN_EVENT_LINE_ZERO = 4'h3;
  localparam lpc_insel_t IN_EVENT_LINE_ONE = 4'h4;
  localparam lpc_insel_t IN_PIN = 4'h5;
  localparam lpc_insel_t IN_PERIPH_A = 4'h6;
  localparam lpc_insel_t IN_PERIPH_B = 4'h7;
endpackage : lpc_pkg

//--- logic/lpc_table_stage.sv
// one table: truth lookup, synchronizer or spike filter, edge detector
`timescale 1ns/1ps
module lpc_table_stage (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire lpc_pkg::lpc_data_t truth,
  input wire logic [2:0] sel,
  input wire lpc_pkg::lpc_filt_t filt_sel,
  input wire logic edge_en,
  input wire logic clk_src,
  output logic stage_out,
  output logic tick
);
  import lpc_pkg::*;

  logic sel2_prev_q, sel2_prev_d;
  logic [2:0] shift_q, shift_d;
  logic gated_q, gated_d;
  logic prev_q, prev_d;
  logic pulse_q, pulse_d;
  logic raw, filt;

  function automatic logic truth_bit(input lpc_data_t t, input logic [2:0] idx);
    truth_bit = t[idx];
  endfunction : truth_bit

  always_comb begin
    // input two becomes the table clock; single clock domain, so its rising edge is a tick
    tick = clk_src ? (sel[2] & ~sel2_prev_q) : 1'b1;
    raw = truth_bit(truth, {sel[2] & ~clk_src, sel[1:0]});
    unique case (filt_sel)
      FILT_SYNC: filt = shift_q[1];
      FILT_FILTER: filt = gated_q;
      default: filt = raw;
    endcase
    stage_out = edge_en ? pulse_q : filt;
  end

  always_comb begin
    sel2_prev_d = sel[2];
    shift_d = shift_q;
    gated_d = gated_q;
    prev_d = prev_q;
    pulse_d = pulse_q;
    if (!enable) begin
      shift_d = 3'h0;
      gated_d = 1'b0;
      prev_d = 1'b0;
      pulse_d = 1'b0;
    end else if (tick) begin
      shift_d = {shift_q[1:0], raw};
      if (shift_q[2] == shift_q[1] && shift_q[1] == shift_q[0]) begin
        gated_d = shift_q[2];
      end
      prev_d = filt;
      pulse_d = filt & ~prev_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel2_prev_q <= 1'b0;
      shift_q <= 3'h0;
      gated_q <= 1'b0;
      prev_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sel2_prev_q <= sel2_prev_d;
      shift_q <= shift_d;
      gated_q <= gated_d;
      prev_q <= prev_d;
      pulse_q <= pulse_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_plain_sync;
    enable && !clk_src && filt_sel == FILT_SYNC && !edge_en;
  endsequence
  sequence s_rise_seen;
    enable && tick && filt && !prev_q;
  endsequence

  AST_SYNC_DELAY: assert property (s_plain_sync [*3] |-> stage_out == $past(raw, 2))
    else $error("synchronized output is not raw delayed by two edges");
  AST_FILTER_CLEAR: assert property (!enable |=> shift_q == 3'h0 && !gated_q)
    else $error("filter state not cleared after disable");
  AST_EDGE_CLEAR: assert property (!enable |=> !pulse_q && !prev_q)
    else $error("edge detector state not cleared after disable");
  AST_EDGE_PULSE: assert property (s_rise_seen |=> pulse_q)
    else $error("rising edge produced no pulse");
  AST_PULSE_LEN: assert property ((enable && !clk_src && pulse_q) |=> !pulse_q)
    else $error("pulse longer than one table clock period");
  AST_TRUTH: assert property ((!edge_en && filt_sel == FILT_OFF && !clk_src) |-> stage_out == truth[sel])
    else $error("table output does not match truth value");
endmodule : lpc_table_stage

//--- logic/lpc_top.sv
// look-up table pair block: configuration, input routing, sequencer, outputs
`timescale 1ns/1ps
module lpc_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire lpc_pkg::lpc_addr_t wr_addr,
  input wire lpc_pkg::lpc_data_t wr_data,
  input wire logic [2:0] tbl0_pin_in,
  input wire logic [2:0] tbl1_pin_in,
  input wire logic event_line_zero,
  input wire logic event_line_one,
  input wire logic periph_a_in,
  input wire logic periph_b_in,
  output logic tbl0_out,
  output logic tbl0_out_oe,
  output logic tbl1_out,
  output logic tbl1_out_oe,
  output logic tbl0_event,
  output logic tbl1_event,
  output logic seq_out,
  output logic block_active
);
  import lpc_pkg::*;

  logic rst_meta_q, rst_n;
  logic glob_en_q, glob_en_d;
  logic [3:0] seq_sel_q, seq_sel_d;
  lpc_data_t ctrl_a_q [NUM_TABLES];
  lpc_data_t ctrl_a_d [NUM_TABLES];
  lpc_data_t ctrl_b_q [NUM_TABLES];
  lpc_data_t ctrl_b_d [NUM_TABLES];
  lpc_data_t ctrl_c_q [NUM_TABLES];
  lpc_data_t ctrl_c_d [NUM_TABLES];
  lpc_data_t truth_q [NUM_TABLES];
  lpc_data_t truth_d [NUM_TABLES];
  logic [NUM_TABLES-1:0] out_q, out_d, oe_q, oe_d, act;
  logic [NUM_TABLES-1:0] stage_out, tick;
  logic [2:0] tsel [NUM_TABLES];
  logic [2:0] pin_in [NUM_TABLES];
  logic seq_q, seq_d, seq_rst_q, seq_rst_d;
  logic active_q, active_d;
  logic even_off_next;

  function automatic lpc_addr_t tbl_addr(input int n, input lpc_addr_t ofs);
    tbl_addr = lpc_addr_t'(ADDR_TBL_BASE + lpc_addr_t'(n) * TBL_STRIDE + ofs);
  endfunction : tbl_addr

  function automatic logic pick_input(input lpc_insel_t code, input logic fb, input logic link,
                                      input logic pin, input logic ev0, input logic ev1,
                                      input logic pa, input logic pb);
    unique case (code)
      IN_FEEDBACK: pick_input = fb;
      IN_LINK: pick_input = link;
      IN_EVENT_LINE_ZERO: pick_input = ev0;
      IN_EVENT_LINE_ONE: pick_input = ev1;
      IN_PIN: pick_input = pin;
      IN_PERIPH_A: pick_input = pa;
      IN_PERIPH_B: pick_input = pb;
      default: pick_input = 1'b0;
    endcase
  endfunction : pick_input

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // configuration writes
  always_comb begin
    glob_en_d = glob_en_q;
    seq_sel_d = seq_sel_q;
    for (int n = 0; n < NUM_TABLES; n++) begin
      ctrl_a_d[n] = ctrl_a_q[n];
      ctrl_b_d[n] = ctrl_b_q[n];
      ctrl_c_d[n] = ctrl_c_q[n];
      truth_d[n] = truth_q[n];
    end
    if (wr_en) begin
      if (wr_addr == ADDR_BLOCK_CTRL) begin
        glob_en_d = wr_data[BC_EN_BIT];
      end
      // sequencer setup is locked by the even table's enable
      if (wr_addr == ADDR_SEQ_CTRL && !ctrl_a_q[0][CA_EN_BIT]) begin
        seq_sel_d = wr_data[3:0];
      end
      for (int n = 0; n < NUM_TABLES; n++) begin
        if (wr_addr == tbl_addr(n, OFS_CTRL_A)) begin
          ctrl_a_d[n][CA_EN_BIT] = wr_data[CA_EN_BIT];
          // any write while enabled changes only the enable bit, so enable-set writes carry fields
          if (!ctrl_a_q[n][CA_EN_BIT]) begin
            ctrl_a_d[n] = wr_data;
          end
        end
        if (wr_addr == tbl_addr(n, OFS_CTRL_B) && !ctrl_a_q[n][CA_EN_BIT]) begin
          ctrl_b_d[n] = wr_data;
        end
        if (wr_addr == tbl_addr(n, OFS_CTRL_C) && !ctrl_a_q[n][CA_EN_BIT]) begin
          ctrl_c_d[n] = wr_data;
        end
        if (wr_addr == tbl_addr(n, OFS_TRUTH)) begin
          truth_d[n] = wr_data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      glob_en_q <= 1'b0;
      seq_sel_q <= SEQ_OFF;
      for (int n = 0; n < NUM_TABLES; n++) begin
        ctrl_a_q[n] <= REG_RESET;
        ctrl_b_q[n] <= REG_RESET;
        ctrl_c_q[n] <= REG_RESET;
        truth_q[n] <= REG_RESET;
      end
    end else begin
      glob_en_q <= glob_en_d;
      seq_sel_q <= seq_sel_d;
      for (int n = 0; n < NUM_TABLES; n++) begin
        ctrl_a_q[n] <= ctrl_a_d[n];
        ctrl_b_q[n] <= ctrl_b_d[n];
        ctrl_c_q[n] <= ctrl_c_d[n];
        truth_q[n] <= truth_d[n];
      end
    end
  end

  // input routing; link uses the registered output so two linked tables cannot form a loop
  always_comb begin
    pin_in[0] = tbl0_pin_in;
    pin_in[1] = tbl1_pin_in;
    for (int n = 0; n < NUM_TABLES; n++) begin
      act[n] = glob_en_q & ctrl_a_q[n][CA_EN_BIT];
      tsel[n][0] = pick_input(ctrl_b_q[n][CB_IN0_LO +: SEL_W], seq_q, out_q[(n + 1) % NUM_TABLES],
                              pin_in[n][0], event_line_zero, event_line_one, periph_a_in, periph_b_in);
      tsel[n][1] = pick_input(ctrl_b_q[n][CB_IN1_LO +: SEL_W], seq_q, out_q[(n + 1) % NUM_TABLES],
                              pin_in[n][1], event_line_zero, event_line_one, periph_a_in, periph_b_in);
      tsel[n][2] = pick_input(ctrl_c_q[n][CC_IN2_LO +: SEL_W], seq_q, out_q[(n + 1) % NUM_TABLES],
                              pin_in[n][2], event_line_zero, event_line_one, periph_a_in, periph_b_in);
    end
  end

  for (genvar g = 0; g < NUM_TABLES; g++) begin : g_tbl
    lpc_table_stage u_stage (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(act[g]),
      .truth(truth_q[g]),
      .sel(tsel[g]),
      .filt_sel(ctrl_a_q[g][CA_FILT_LO +: 2]),
      .edge_en(ctrl_a_q[g][CA_EDGE_BIT]),
      .clk_src(ctrl_a_q[g][CA_TABLE_CLOCK_SOURCE_BIT]),
      .stage_out(stage_out[g]),
      .tick(tick[g])
    );
  end

  // sequencer; latch modes are transparent per system clock, no true latches in this design
  always_comb begin
    even_off_next = ~(glob_en_d & ctrl_a_d[0][CA_EN_BIT]);
    seq_rst_d = ~act[0];
    seq_d = seq_q;
    if (even_off_next || seq_rst_q) begin
      seq_d = 1'b0;
    end else begin
      unique case (seq_sel_q)
        SEQ_DFF: if (tick[0] && stage_out[1]) seq_d = stage_out[0];
        SEQ_JK: begin
          if (tick[0]) begin
            unique case ({stage_out[0], stage_out[1]})
              2'h1: seq_d = 1'b0;
              2'h2: seq_d = 1'b1;
              2'h3: seq_d = ~seq_q;
              default: seq_d = seq_q;
            endcase
          end
        end
        SEQ_DLATCH: if (stage_out[1]) seq_d = stage_out[0];
        SEQ_RS: begin
          // both inputs high is forbidden; we simply hold
          if (stage_out[0] && !stage_out[1]) seq_d = 1'b1;
          else if (!stage_out[0] && stage_out[1]) seq_d = 1'b0;
        end
        default: seq_d = 1'b0;
      endcase
    end
  end

  // outputs
  always_comb begin
    for (int n = 0; n < NUM_TABLES; n++) begin
      out_d[n] = act[n] & stage_out[n];
      oe_d[n] = act[n] & ctrl_a_q[n][CA_OUTEN_BIT];
    end
    active_d = glob_en_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= 1'b0;
      seq_rst_q <= 1'b1;
      out_q <= '0;
      oe_q <= '0;
      active_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      seq_rst_q <= seq_rst_d;
      out_q <= out_d;
      oe_q <= oe_d;
      active_q <= active_d;
    end
  end

  assign tbl0_out = out_q[0];
  assign tbl1_out = out_q[1];
  assign tbl0_event = out_q[0];
  assign tbl1_event = out_q[1];
  assign tbl0_out_oe = oe_q[0];
  assign tbl1_out_oe = oe_q[1];
  assign seq_out = seq_q;
  assign block_active = active_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_seq_run;
    act[0] && !seq_rst_q && glob_en_d && ctrl_a_d[0][CA_EN_BIT];
  endsequence
  sequence s_latch_open;
    seq_sel_q == SEQ_DLATCH && stage_out[1];
  endsequence
  sequence s_rs_set;
    seq_sel_q == SEQ_RS && stage_out[0] && !stage_out[1];
  endsequence

  AST_SEQ_LOCK: assert property (ctrl_a_q[0][CA_EN_BIT] |=> seq_sel_q == $past(seq_sel_q))
    else $error("sequencer select changed while even table enabled");
  AST_CTRL_LOCK: assert property ((wr_en && wr_addr == tbl_addr(0, OFS_CTRL_A) && ctrl_a_q[0][CA_EN_BIT]
                                   && !wr_data[CA_EN_BIT]) |=> ctrl_a_q[0] == ($past(ctrl_a_q[0]) & 8'hfe))
    else $error("protected fields changed by disabling write");
  AST_CTRL_SETEN: assert property ((wr_en && wr_addr == tbl_addr(1, OFS_CTRL_A) && !ctrl_a_q[1][CA_EN_BIT])
                                   |=> ctrl_a_q[1] == $past(wr_data))
    else $error("enable-set write did not load protected fields");
  AST_GLOBAL: assert property ((wr_en && wr_addr == ADDR_BLOCK_CTRL)
                               |=> glob_en_q == $past(wr_data[BC_EN_BIT]))
    else $error("global enable did not follow write");
  AST_OFF_LOW: assert property (!act[1] |=> !tbl1_out && !tbl1_event && !tbl1_out_oe)
    else $error("disabled table drives its output");
  AST_SEQ_CLEAR: assert property (!act[0] |=> !seq_q ##1 !seq_q)
    else $error("sequencer not cleared after even disable");
  AST_JK_TOGGLE: assert property ((s_seq_run and (seq_sel_q == SEQ_JK && tick[0] && stage_out[0] && stage_out[1]))
                                  |=> seq_q != $past(seq_q))
    else $error("jk flop did not toggle");
  AST_DFF_HOLD: assert property ((s_seq_run and (seq_sel_q == SEQ_DFF && !stage_out[1])) |=> $stable(seq_q))
    else $error("data flop changed with gate low");
  AST_DFF_LOAD: assert property ((s_seq_run and (seq_sel_q == SEQ_DFF && tick[0] && stage_out[1]))
                                 |=> seq_q == $past(stage_out[0]))
    else $error("data flop did not load with gate high");
  AST_LATCH_FOLLOW: assert property ((s_seq_run and s_latch_open) |=> seq_q == $past(stage_out[0]))
    else $error("data latch does not follow data with gate high");
  AST_RS_SET: assert property ((s_seq_run and s_rs_set) |=> seq_q)
    else $error("set input did not set the latch");
  AST_RESERVED_OFF: assert property ((seq_sel_q > SEQ_RS) |=> !seq_q)
    else $error("reserved sequencer code drives output");
  AST_OUT_FOLLOW: assert property (act[0] |=> tbl0_out == $past(stage_out[0]))
    else $error("active table output does not follow its stage");
  AST_ACTIVE_FLAG: assert property (block_active == $past(glob_en_q))
    else $error("block active flag does not follow global enable");
endmodule : lpc_top

//--- test/lpc_far_model.sv
// far-side model: dedicated pins, event lines and peripheral signals
`timescale 1ns/1ps
module lpc_far_model (
  input wire logic sys_clk,
  output logic [2:0] tbl0_pin_in,
  output logic [2:0] tbl1_pin_in,
  output logic event_line_zero,
  output logic event_line_one,
  output logic periph_a_in,
  output logic periph_b_in
);
  // want: [9:7] tbl1 pins, [6:4] tbl0 pins, [3] ev1, [2] ev0, [1] periph b, [0] periph a
  logic [9:0] want;
  initial begin
    want = 10'h000;
    {tbl1_pin_in, tbl0_pin_in, event_line_one, event_line_zero, periph_b_in, periph_a_in} = 10'h000;
  end
  // levels move on the falling edge only, never near the sampling edge
  always @(negedge sys_clk) begin
    {tbl1_pin_in, tbl0_pin_in, event_line_one, event_line_zero, periph_b_in, periph_a_in} <= want;
  end
  // levels passed in here reach the pins at the next falling edge
  task automatic put(input logic [9:0] v);
    want = v;
  endtask : put
endmodule : lpc_far_model

//--- test/tb_lpc_top.sv
// self-checking bench for the look-up table pair block
`timescale 1ns/1ps
module tb_lpc_top;
  import lpc_pkg::*;
  logic sys_clk;
  logic rst_b;
  logic wr_en;
  lpc_addr_t wr_addr;
  lpc_data_t wr_data;
  logic [2:0] tbl0_pin_in;
  logic [2:0] tbl1_pin_in;
  logic event_line_zero;
  logic event_line_one;
  logic periph_a_in;
  logic periph_b_in;
  logic tbl0_out;
  logic tbl0_out_oe;
  logic tbl1_out;
  logic tbl1_out_oe;
  logic tbl0_event;
  logic tbl1_event;
  logic seq_out;
  logic block_active;
  int err_total;
  int checks_done;
  logic [7:0] seq_rows [15];
  lpc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .tbl0_pin_in(tbl0_pin_in), .tbl1_pin_in(tbl1_pin_in), .event_line_zero(event_line_zero),
    .event_line_one(event_line_one), .periph_a_in(periph_a_in), .periph_b_in(periph_b_in),
    .tbl0_out(tbl0_out), .tbl0_out_oe(tbl0_out_oe), .tbl1_out(tbl1_out), .tbl1_out_oe(tbl1_out_oe),
    .tbl0_event(tbl0_event), .tbl1_event(tbl1_event), .seq_out(seq_out), .block_active(block_active));
  lpc_far_model far (.sys_clk(sys_clk), .tbl0_pin_in(tbl0_pin_in), .tbl1_pin_in(tbl1_pin_in),
    .event_line_zero(event_line_zero), .event_line_one(event_line_one), .periph_a_in(periph_a_in),
    .periph_b_in(periph_b_in));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  // strobe stays high across back-to-back calls, so no double assignment per step
  task automatic wr(input lpc_addr_t a, input lpc_data_t d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
  endtask : wr
  task automatic idle(input int n);
    @(negedge sys_clk);
    wr_en = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask : idle
  function automatic lpc_addr_t ta(input int n, input lpc_addr_t ofs);
    return lpc_addr_t'(ADDR_TBL_BASE + TBL_STRIDE * n + ofs);
  endfunction : ta
  // disable first so the protected fields are open, enable last
  task automatic cfg(input int n, input lpc_data_t a, input lpc_data_t b, input lpc_data_t c, input lpc_data_t t);
    wr(ta(n, OFS_CTRL_A), 8'h00);
    wr(ta(n, OFS_CTRL_B), b);
    wr(ta(n, OFS_CTRL_C), c);
    wr(ta(n, OFS_TRUTH), t);
    wr(ta(n, OFS_CTRL_A), a);
    idle(6);
  endtask : cfg
  task automatic s_reset();
    chk("out0 reset", 1'b0, tbl0_out);
    chk("out1 reset", 1'b0, tbl1_out);
    chk("seq reset", 1'b0, seq_out);
    chk("active reset", 1'b0, block_active);
  endtask : s_reset
  task automatic s_truth();
    cfg(0, 8'h01, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h00);
    cfg(1, 8'h01, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(ta(0, OFS_TRUTH), lpc_data_t'(8'h01 << k));
      wr(ta(1, OFS_TRUTH), lpc_data_t'(8'h80 >> k));
      for (int i = 0; i < 8; i++) begin
        far.put({3'(i), 3'(i), 4'h0});
        idle(4);
        chk("truth out", i == k, tbl0_out);
        chk("truth event", i == k, tbl0_event);
        chk("truth1 out", i == 7 - k, tbl1_out);
        chk("truth1 event", i == 7 - k, tbl1_event);
      end
    end
  endtask : s_truth
  task automatic s_inputs();
    logic e;
    logic [3:0] sel;
    cfg(1, 8'h01, 8'h00, 8'h00, 8'hff);
    for (int c = 0; c < 8; c++) begin
      sel = c[3:0];
      cfg(0, 8'h01, {4'h0, sel}, 8'h00, 8'h02);
      for (int v = 0; v < 2; v++) begin
        far.put(v == 1 ? 10'h015 : 10'h00a);
        idle(4);
        case (sel)
          IN_LINK: e = 1'b1;
          IN_EVENT_LINE_ZERO, IN_PIN, IN_PERIPH_A: e = v[0];
          IN_EVENT_LINE_ONE, IN_PERIPH_B: e = ~v[0];
          default: e = 1'b0;
        endcase
        chk("input select", e, tbl0_out);
      end
    end
  endtask : s_inputs
  task automatic s_protect();
    cfg(0, 8'h01, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h02);
    far.put(10'h010);
    wr(ta(0, OFS_CTRL_B), 8'h00);
    idle(4);
    chk("locked ctrl b", 1'b1, tbl0_out);
    wr(ta(0, OFS_CTRL_A), 8'h08);
    idle(4);
    chk("disabled out", 1'b0, tbl0_out);
    chk("oe on disable write", 1'b0, tbl0_out_oe);
    wr(ta(0, OFS_CTRL_A), 8'h09);
    idle(4);
    chk("re-enabled out", 1'b1, tbl0_out);
    chk("oe on enable write", 1'b1, tbl0_out_oe);
    wr(ADDR_BLOCK_CTRL, 8'h00);
    idle(4);
    chk("global off out", 1'b0, tbl0_out);
    chk("global off flag", 1'b0, block_active);
    wr(ADDR_BLOCK_CTRL, 8'h01);
    idle(4);
    chk("global on out", 1'b1, tbl0_out);
    chk("global on flag", 1'b1, block_active);
    // input two becomes the table clock and reads low in the lookup
    far.put(10'h070);
    cfg(0, 8'h41, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'hf0);
    chk("clock source input", 1'b0, tbl0_out);
  endtask : s_protect
  task automatic lat(input lpc_filt_t m, output int n);
    cfg(0, {2'b00, m, 4'h1}, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h02);
    far.put(10'h000);
    idle(6);
    far.put(10'h010);
    n = 0;
    while (tbl0_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : lat
  task automatic s_filter();
    int b;
    int n;
    int hi;
    lat(FILT_OFF, b);
    lat(FILT_SYNC, n);
    chk("sync delay", 1'b1, n == b + 2);
    lat(FILT_FILTER, n);
    chk("filter delay", 1'b1, n == b + 4);
    far.put(10'h000);
    idle(8);
    far.put(10'h010);
    idle(1);
    far.put(10'h000);
    hi = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (tbl0_out === 1'b1) hi++;
    end
    chk("spike blocked", 1'b1, hi == 0);
    // edge detect paired with the synchronizer, never alone
    cfg(0, 8'h91, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h02);
    far.put(10'h010);
    repeat (14) begin
      @(negedge sys_clk);
      if (tbl0_out === 1'b1) hi++;
    end
    chk("edge pulse", 1'b1, hi == 1);
  endtask : s_filter
  task automatic s_seq();
    logic [3:0] md;
    logic a;
    md = 4'hf;
    cfg(1, 8'h01, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h02);
    cfg(0, 8'h01, {IN_PIN, IN_PIN}, {4'h0, IN_PIN}, 8'h02);
    foreach (seq_rows[r]) begin
      if (seq_rows[r][7:4] != md) begin
        md = seq_rows[r][7:4];
        wr(ta(0, OFS_CTRL_A), 8'h00);
        wr(ADDR_SEQ_CTRL, {4'h0, md});
        wr(ta(0, OFS_CTRL_A), 8'h01);
      end
      far.put({2'b00, seq_rows[r][2], 2'b00, seq_rows[r][3], 4'h0});
      idle(6);
      a = seq_out;
      if (seq_rows[r][1:0] == 2'd2) begin
        @(negedge sys_clk);
        chk("jk toggle", ~a, seq_out);
      end else begin
        chk("sequencer out", seq_rows[r][0], seq_out);
      end
    end
    far.put(10'h010);
    idle(6);
    chk("rs set", 1'b1, seq_out);
    cfg(1, 8'h01, {IN_MASK, IN_FEEDBACK}, 8'h00, 8'h02);
    chk("feedback in", 1'b1, tbl1_out);
    wr(ta(0, OFS_CTRL_A), 8'h00);
    idle(2);
    chk("seq clear", 1'b0, seq_out);
    chk("feedback clear", 1'b0, tbl1_out);
  endtask : s_seq
  initial begin
    // row: mode, even input, odd input, expected (2 = toggles)
    seq_rows = '{{SEQ_OFF, 4'b1100}, {4'h5, 4'b1100}, {SEQ_DFF, 4'b1101}, {SEQ_DFF, 4'b0001},
      {SEQ_DFF, 4'b0100}, {SEQ_JK, 4'b1001}, {SEQ_JK, 4'b0001}, {SEQ_JK, 4'b0100}, {SEQ_JK, 4'b1110},
      {SEQ_DLATCH, 4'b1101}, {SEQ_DLATCH, 4'b0001}, {SEQ_DLATCH, 4'b0100},
      {SEQ_RS, 4'b1001}, {SEQ_RS, 4'b0001}, {SEQ_RS, 4'b0100}};
    err_total = 0;
    checks_done = 0;
    rst_b = 1'b0;
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 8'h00;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    s_reset();
    wr(ADDR_BLOCK_CTRL, 8'h01);
    idle(2);
    s_truth();
    s_inputs();
    s_protect();
    s_filter();
    s_seq();
    report_and_stop();
  end
  // whole run is under a thousand cycles; this bound only trips on a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
endmodule : tb_lpc_top
